// ### core/qt_pkg.sv
package qt_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int QT_ADDR_W = 8;
    localparam int QT_BYTE_W = 8;
    localparam int QT_DQ_W = 16;
    localparam int QT_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Query space map
    // ------------------------------------------------------------
    localparam logic [7:0] QT_BASE_PTR_ADDR = 8'h15;
    localparam logic [7:0] QT_BASE_PTR = 8'h39;
    localparam logic [7:0] QT_REGION_COUNT_ADDR = 8'h52;
    localparam logic [7:0] QT_REGION_COUNT = 8'h02;
    localparam logic [7:0] QT_REGION1_BASE = 8'h53;
    localparam logic [7:0] QT_REGION2_BASE_BOT = 8'h69;
    localparam logic [7:0] QT_REGION2_BASE_TOP = 8'h61;
    localparam logic [7:0] QT_FEATURE_ADDR = 8'h77;
    localparam logic [7:0] QT_FEATURE_RSVD = 8'h00;
    localparam logic [7:0] QT_UNMAPPED = 8'h00;

    // Region 2 registers, bottom-parameter layout
    localparam logic [7:0] QT_REG_REGION2_PARTITION_COUNT = 8'h69;
    localparam logic [7:0] QT_REG_REGION2_INTRA_PARTITION_OPS = 8'h6b;
    localparam logic [7:0] QT_REG_REGION2_OPS_WHILE_PROGRAMMING = 8'h6c;
    localparam logic [7:0] QT_REG_REGION2_OPS_WHILE_ERASING = 8'h6d;
    localparam logic [7:0] QT_REG_REGION2_BLOCK_TYPE_COUNT = 8'h6e;
    localparam logic [7:0] QT_REG_REGION2_TYPE1_GEOMETRY = 8'h6f;
    localparam logic [7:0] QT_REG_REGION2_TYPE1_ENDURANCE = 8'h73;
    localparam logic [7:0] QT_REG_REGION2_TYPE1_CELL_BITS = 8'h75;
    localparam logic [7:0] QT_REG_REGION2_TYPE1_READ_WRITE_CAPS = 8'h76;
    localparam logic [7:0] QT_REG_FEATURE_SPACE_RESERVED = 8'h77;

    // ------------------------------------------------------------
    // Field offsets within a region record and a descriptor set
    // ------------------------------------------------------------
    localparam logic [7:0] QT_FLD_COUNT = 8'h00;
    localparam logic [7:0] QT_FLD_INTRA = 8'h02;
    localparam logic [7:0] QT_FLD_PROG = 8'h03;
    localparam logic [7:0] QT_FLD_ERASE = 8'h04;
    localparam logic [7:0] QT_FLD_TYPES = 8'h05;
    localparam logic [7:0] QT_FLD_DESC1 = 8'h06;
    localparam logic [7:0] QT_FLD_DESC2 = 8'h0e;
    localparam logic [7:0] QT_LEN_MAIN = 8'h0e;
    localparam logic [7:0] QT_LEN_MIXED = 8'h16;
    localparam logic [7:0] QT_DSC_ENDUR = 8'h04;
    localparam logic [7:0] QT_DSC_CELL = 8'h06;
    localparam logic [7:0] QT_DSC_CAPS = 8'h07;

    // ------------------------------------------------------------
    // Field values and bit positions
    // ------------------------------------------------------------
    localparam logic [7:0] QT_OPS_INTRA = 8'h11;
    localparam logic [7:0] QT_OPS_OTHER = 8'h00;
    localparam logic [7:0] QT_TYPES_MAIN = 8'h01;
    localparam logic [7:0] QT_TYPES_MIXED = 8'h02;
    localparam logic [15:0] QT_MAIN_Y_FULL = 16'h0007;
    localparam logic [15:0] QT_MAIN_Y_MIXED = 16'h0006;
    localparam logic [15:0] QT_PARAM_Y = 16'h0007;
    localparam logic [15:0] QT_MAIN_Z = 16'h0100;
    localparam logic [15:0] QT_PARAM_Z = 16'h0020;
    localparam logic [15:0] QT_ENDURANCE = 16'h0064;
    localparam logic [7:0] QT_CELL_BITS = 8'h01;
    localparam logic [7:0] QT_RW_CAPS = 8'h03;
    localparam int QT_PARTITION_MBIT = 4;
    localparam int QT_BLOCK_UNIT = 256;
    localparam int QT_ENDUR_UNIT = 1000;
    localparam int QT_PROG_LSB = 0;
    localparam int QT_ERASE_LSB = 4;
    localparam int QT_CELL_ECC_BIT = 4;
    localparam int QT_CAP_PAGE_READ = 0;
    localparam int QT_CAP_SYNC_READ = 1;
    localparam int QT_CAP_SYNC_WRITE = 2;

endpackage

// ### core/qt_sync.sv
`timescale 1ns/10ps
module qt_sync
    import qt_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic RESET_VAL = 1'b0
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // Two flops; the first is read only by the second
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= {WIDTH{RESET_VAL}};
            sync_out <= {WIDTH{RESET_VAL}};
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// ### core/qt_rom.sv
`timescale 1ns/10ps
module qt_rom
    import qt_pkg::*;
#(
    parameter int DENSITY_MBIT = 32,
    parameter bit TOP_PARAM_VARIANT = 1'b0
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Read port
    input wire logic rd_en,
    input wire logic [QT_ADDR_W-1:0] rd_addr,
    output logic [QT_BYTE_W-1:0] rd_data
);

    localparam logic [15:0] MAIN_PARTS = 16'(DENSITY_MBIT / QT_PARTITION_MBIT - 1);

    // One byte of a descriptor set, little-endian multi-byte fields
    function automatic logic [7:0] desc_byte(input logic [7:0] idx, input logic [15:0] y, input logic [15:0] z);
        logic [7:0] b;
        b = QT_UNMAPPED;
        case (idx)
            8'h00: b = y[7:0];
            8'h01: b = y[15:8];
            8'h02: b = z[7:0];
            8'h03: b = z[15:8];
            QT_DSC_ENDUR: b = QT_ENDURANCE[7:0];
            8'h05: b = QT_ENDURANCE[15:8];
            QT_DSC_CELL: b = QT_CELL_BITS;
            QT_DSC_CAPS: b = QT_RW_CAPS;
            default: b = QT_UNMAPPED;
        endcase
        return b;
    endfunction

    // One byte of a region record; mixed regions carry two descriptor sets
    function automatic logic [7:0] region_byte(input logic [7:0] off, input logic [15:0] parts,
                                               input logic mixed, input logic param_first);
        logic [7:0] b;
        b = QT_UNMAPPED;
        if (off == QT_FLD_COUNT)
            b = parts[7:0];
        else if (off == QT_FLD_COUNT + 8'h01)
            b = parts[15:8];
        else if (off == QT_FLD_INTRA)
            b = QT_OPS_INTRA;
        else if (off == QT_FLD_PROG || off == QT_FLD_ERASE)
            b = QT_OPS_OTHER;
        else if (off == QT_FLD_TYPES)
            b = mixed ? QT_TYPES_MIXED : QT_TYPES_MAIN;
        else if (off < QT_FLD_DESC2)
        begin
            if (!mixed)
                b = desc_byte(off - QT_FLD_DESC1, QT_MAIN_Y_FULL, QT_MAIN_Z);
            else if (param_first)
                b = desc_byte(off - QT_FLD_DESC1, QT_PARAM_Y, QT_PARAM_Z);
            else
                b = desc_byte(off - QT_FLD_DESC1, QT_MAIN_Y_MIXED, QT_MAIN_Z);
        end
        // Second descriptor set only in a mixed region
        else if (mixed && param_first)
            b = desc_byte(off - QT_FLD_DESC2, QT_MAIN_Y_MIXED, QT_MAIN_Z);
        else if (mixed)
            b = desc_byte(off - QT_FLD_DESC2, QT_PARAM_Y, QT_PARAM_Z);
        return b;
    endfunction

    localparam logic [7:0] LEN1 = TOP_PARAM_VARIANT ? QT_LEN_MAIN : QT_LEN_MIXED;
    localparam logic [7:0] R2_BASE = QT_REGION1_BASE + LEN1;
    localparam logic [7:0] LEN2 = TOP_PARAM_VARIANT ? QT_LEN_MIXED : QT_LEN_MAIN;

    // Whole query map for the chosen variant
    function automatic logic [7:0] query_byte(input logic [7:0] a);
        logic [7:0] b;
        b = QT_UNMAPPED;
        if (a == QT_BASE_PTR_ADDR)
            b = QT_BASE_PTR;
        else if (a == QT_BASE_PTR_ADDR + 8'h01)
            b = 8'h00;
        else if (a == QT_REGION_COUNT_ADDR)
            b = QT_REGION_COUNT;
        else if (a >= QT_REGION1_BASE && a < R2_BASE)
            b = TOP_PARAM_VARIANT ? region_byte(a - QT_REGION1_BASE, MAIN_PARTS, 1'b0, 1'b0)
                                  : region_byte(a - QT_REGION1_BASE, 16'h0001, 1'b1, 1'b1);
        else if (a >= R2_BASE && a < R2_BASE + LEN2)
            b = TOP_PARAM_VARIANT ? region_byte(a - R2_BASE, 16'h0001, 1'b1, 1'b0)
                                  : region_byte(a - R2_BASE, MAIN_PARTS, 1'b0, 1'b0);
        else if (a == QT_FEATURE_ADDR)
            b = QT_FEATURE_RSVD;
        return b;
    endfunction

    // Registered read; holds the last byte while not selected
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= QT_UNMAPPED;
        else if (rd_en)
            rd_data <= query_byte(rd_addr);
    end

endmodule

// ### core/qt_query_table.sv
`timescale 1ns/10ps
module qt_query_table
    import qt_pkg::*;
#(
    parameter int DENSITY_MBIT = 32,
    parameter bit TOP_PARAM_VARIANT = 1'b0
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Host read pins
    input wire logic [QT_ADDR_W-1:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    // Data pins
    output logic [QT_DQ_W-1:0] dq_out,
    output logic dq_oe_n
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    initial
    begin
        if (DENSITY_MBIT != 32 && DENSITY_MBIT != 64 && DENSITY_MBIT != 128)
            $error("qt_query_table: density must be 32, 64 or 128 Mbit");
    end

    // Layout derived from the variant
    localparam logic [7:0] R2_BASE = TOP_PARAM_VARIANT ? QT_REGION2_BASE_TOP : QT_REGION2_BASE_BOT;
    localparam logic [7:0] R_MAIN = TOP_PARAM_VARIANT ? QT_REGION1_BASE : QT_REGION2_BASE_BOT;
    localparam logic [7:0] R_MIXED = TOP_PARAM_VARIANT ? QT_REGION2_BASE_TOP : QT_REGION1_BASE;
    localparam logic [15:0] MAIN_PARTS = 16'(DENSITY_MBIT / QT_PARTITION_MBIT - 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [QT_ADDR_W-1:0] addr_s;
    logic ce_n_s;
    logic oe_n_s;
    logic active;
    logic [QT_ADDR_W-1:0] out_addr;
    logic [QT_BYTE_W-1:0] rom_data;

    // Address bits may skew across the sync; host changes address just after an edge, together with the strobes
    qt_sync #(.WIDTH(QT_ADDR_W), .RESET_VAL(1'b0)) u_sync_addr
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(addr),
        .sync_out(addr_s)
    );

    // Strobes idle high
    qt_sync #(.WIDTH(2), .RESET_VAL(1'b1)) u_sync_ctl
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({ce_n, oe_n}),
        .sync_out({ce_n_s, oe_n_s})
    );

    assign active = !ce_n_s && !oe_n_s;

    // ------------------------------------------------------------
    // Query store
    // ------------------------------------------------------------
    qt_rom #(.DENSITY_MBIT(DENSITY_MBIT), .TOP_PARAM_VARIANT(TOP_PARAM_VARIANT)) u_rom
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rd_en(active),
        .rd_addr(addr_s),
        .rd_data(rom_data)
    );

    // Byte lane: query data on the low byte, upper byte zero
    assign dq_out = {8'h00, rom_data};

    // Drive enable follows the read one cycle late, aligned with the registered byte
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            dq_oe_n <= 1'b1;
        else
            dq_oe_n <= !active;
    end

    // Address of the byte now on the pins, kept for checking
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            out_addr <= '0;
        else if (active)
            out_addr <= addr_s;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_layout_offsets : assert property (@(posedge ref_clk) disable iff (!rst_n)
        R2_BASE == (TOP_PARAM_VARIANT ? QT_REGION2_BASE_TOP : QT_REG_REGION2_PARTITION_COUNT)
        && QT_BASE_PTR + 8'h30 == QT_REG_REGION2_PARTITION_COUNT)
        else $error("region 2 base offset wrong");

    a_r2_count_lo : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R2_BASE)
        |-> dq_out[7:0] == (TOP_PARAM_VARIANT ? 8'h01 : MAIN_PARTS[7:0]))
        else $error("region 2 partition count low byte wrong");

    a_count_order : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R_MAIN && active && addr_s == R_MAIN + 8'h01)
        |=> dq_out[7:0] == MAIN_PARTS[15:8] && $past(dq_out[7:0]) == MAIN_PARTS[7:0])
        else $error("multi-byte count not low byte first");

    a_intra_ops : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R2_BASE + QT_FLD_INTRA)
        |-> dq_out[QT_PROG_LSB +: 4] == 4'h1 && dq_out[QT_ERASE_LSB +: 4] == 4'h1)
        else $error("intra-partition nibbles wrong");

    a_ops_programming : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R2_BASE + QT_FLD_PROG) |-> dq_out[7:0] == QT_OPS_OTHER)
        else $error("ops while programming wrong");

    a_ops_erasing : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R2_BASE + QT_FLD_ERASE) |-> dq_out[7:0] == QT_OPS_OTHER)
        else $error("ops while erasing wrong");

    a_type_count : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R2_BASE + QT_FLD_TYPES)
        |-> dq_out[7:0] != 8'h00 && dq_out[7:0] == (TOP_PARAM_VARIANT ? QT_TYPES_MIXED : QT_TYPES_MAIN))
        else $error("block type count wrong");

    a_geo_size : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R_MAIN + QT_FLD_DESC1 + 8'h03)
        |-> 32'(dq_out[7:0]) * 32'(QT_BLOCK_UNIT) * 32'd256 == 32'd65536)
        else $error("main block size field wrong");

    a_geo_count : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R_MAIN + QT_FLD_DESC1) |-> dq_out[7:0] + 8'h01 == 8'h08)
        else $error("main block count field wrong");

    a_endurance : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R2_BASE + QT_FLD_DESC1 + QT_DSC_ENDUR)
        |-> 32'(dq_out[7:0]) * 32'(QT_ENDUR_UNIT) == 32'd100000)
        else $error("endurance field wrong");

    a_cell_bits : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R2_BASE + QT_FLD_DESC1 + QT_DSC_CELL)
        |-> dq_out[3:0] == 4'h1 && dq_out[7:QT_CELL_ECC_BIT] == 4'h0)
        else $error("cell bits byte wrong");

    a_rw_caps : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R2_BASE + QT_FLD_DESC1 + QT_DSC_CAPS)
        |-> dq_out[QT_CAP_PAGE_READ] && dq_out[QT_CAP_SYNC_READ]
            && !dq_out[QT_CAP_SYNC_WRITE] && dq_out[7:3] == 5'h00)
        else $error("capability byte wrong");

    a_second_set : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R2_BASE + QT_FLD_DESC2)
        |-> dq_out[7:0] == (TOP_PARAM_VARIANT ? QT_PARAM_Y[7:0] : QT_FEATURE_RSVD))
        else $error("second region 2 descriptor set misplaced");

    a_feature_rsvd : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == QT_FEATURE_ADDR) |-> dq_out[7:0] == QT_FEATURE_RSVD)
        else $error("feature space not reserved");

    a_byte_55 : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == QT_REGION1_BASE + QT_FLD_INTRA) |-> dq_out[7:0] == 8'h11)
        else $error("byte 55h not 11h");

    a_partition_size : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R_MAIN)
        |-> (32'(dq_out[7:0]) + 32'd1) * 32'(QT_PARTITION_MBIT) == 32'(DENSITY_MBIT))
        else $error("partition count does not match density");

    a_mixed_single : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == R_MIXED) |-> dq_out[7:0] == 8'h01)
        else $error("mixed region must hold one partition");

    a_region_count : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == QT_REGION_COUNT_ADDR) |-> dq_out[7:0] == QT_REGION_COUNT)
        else $error("partition region count wrong");

    a_base_ptr : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!dq_oe_n && out_addr == QT_BASE_PTR_ADDR) |-> dq_out[7:0] == QT_BASE_PTR)
        else $error("base pointer wrong");

    a_read_timing : assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(ce_n_s || oe_n_s) |=> !dq_oe_n)
        else $error("drive enable late");

    a_upper_zero : assert property (@(posedge ref_clk) disable iff (!rst_n)
        !dq_oe_n |-> dq_out[15:8] == 8'h00 ##1 (dq_oe_n || $stable(dq_out[15:8])))
        else $error("upper data byte not zero");

endmodule

// ### sim/qt_host_model.sv
`timescale 1ns/10ps
module qt_host_model
    import qt_pkg::*;
(
    // Clock
    ref_clk,
    // Host read pins
    addr,
    ce_n,
    oe_n,
    // Data pins
    dq_out,
    dq_oe_n
);
    input wire logic ref_clk;
    output logic [QT_ADDR_W-1:0] addr;
    output logic ce_n;
    output logic oe_n;
    input wire logic [QT_DQ_W-1:0] dq_out;
    input wire logic dq_oe_n;

    localparam int DLY = 2;
    logic [QT_ADDR_W-1:0] base;

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Idle pins at time zero, nothing selected
    initial
    begin
        addr = 8'h00;
        ce_n = 1'b1;
        oe_n = 1'b1;
        base = 8'h00;
    end

    // Select a byte; pins move just after an edge so the sync flops see one clean change
    task automatic point(input logic [QT_ADDR_W-1:0] a);
        @(posedge ref_clk);
        #DLY;
        addr = a;
        ce_n = 1'b0;
        oe_n = 1'b0;
    endtask

    // Offsets are taken from the pointer, never from fixed addresses
    task automatic point_rel(input logic [QT_ADDR_W-1:0] off);
        point(base + off);
    endtask

    // Deselect; the address is scrambled since a released bus carries no meaning
    task automatic release_pins();
        ce_n = 1'b1;
        oe_n = 1'b1;
        addr = ~addr;
    endtask

    // Full read with bounded waits for drive on and drive off
    task automatic read_abs(input logic [QT_ADDR_W-1:0] a, output logic [QT_DQ_W-1:0] d, output int lon,
                            output int loff);
        point(a);
        lon = 0;
        do
        begin
            @(posedge ref_clk);
            #DLY;
            lon++;
        end
        while (dq_oe_n !== 1'b0 && lon < 8);
        d = dq_out;
        release_pins();
        loff = 0;
        do
        begin
            @(posedge ref_clk);
            #DLY;
            loff++;
        end
        while (dq_oe_n !== 1'b1 && loff < 8);
    endtask

    // Pointer fetch from the fixed base location
    task automatic fetch_base();
        logic [QT_DQ_W-1:0] d;
        int lon;
        int loff;
        read_abs(QT_BASE_PTR_ADDR, d, lon, loff);
        base = d[7:0];
    endtask
endmodule

// ### sim/tb_partition_region_query_table.sv
`timescale 1ns/10ps
module tb_partition_region_query_table;
    import qt_pkg::*;
    localparam int DENS_B = 32;
    localparam int DENS_T = 128;
    localparam int DLY = 2;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [QT_ADDR_W-1:0] addr;
    logic ce_n;
    logic oe_n;
    logic [QT_DQ_W-1:0] dq_b;
    logic [QT_DQ_W-1:0] dq_t;
    logic oe_b_n;
    logic oe_t_n;
    int mismatches = 0;
    int checks_done = 0;
    logic [7:0] exp_b [0:22];
    logic [7:0] exp_t [0:22];
    logic [7:0] got_b [0:22];
    logic [7:0] got_t [0:22];

    // ------------------------------------------------------------
    // Devices and host
    // ------------------------------------------------------------
    // Both variants share the host pins; only the bottom part answers the handshake
    qt_query_table #(.DENSITY_MBIT(DENS_B), .TOP_PARAM_VARIANT(1'b0)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .dq_out(dq_b), .dq_oe_n(oe_b_n));
    qt_query_table #(.DENSITY_MBIT(DENS_T), .TOP_PARAM_VARIANT(1'b1)) uut_top (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .dq_out(dq_t), .dq_oe_n(oe_t_n));
    qt_host_model host (.ref_clk(ref_clk), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .dq_out(dq_b), .dq_oe_n(oe_b_n));

    // Clock at 100 ns
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One read on both parts; drive comes on the third edge after the pins move, since they always move just after an edge
    task automatic rd(input logic [7:0] a, input logic [7:0] eb, input logic [7:0] et);
        logic [QT_DQ_W-1:0] d;
        int lon;
        int loff;
        host.read_abs(a, d, lon, loff);
        check(32'(d), {24'h0, eb});
        check(32'(dq_b), {24'h0, eb});
        check(32'(dq_t), {24'h0, et});
        check(32'(lon >= 2 && lon <= 3), 32'h1);
        check(32'(loff >= 2 && loff <= 3 && oe_t_n === 1'b1), 32'h1);
    endtask

    // Blocks plus one, times size in 256-byte units, in bits
    function automatic logic [31:0] geo_bits(input logic [7:0] b0, b1, b2, b3);
        return (32'({b1, b0}) + 32'h1) * 32'({b3, b2}) * 32'd2048;
    endfunction

    // Watchdog well above the roughly 160 cycles the tests need
    initial
    begin
        #(20000 * 100);
        mismatches++;
        summarize();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        exp_b = '{8'h06, 8'h00, 8'h00, 8'h01, 8'h64, 8'h00, 8'h01, 8'h03, 8'h00, 8'h00, 8'h11, 8'h00,
                  8'h00, 8'h01, 8'h07, 8'h00, 8'h00, 8'h01, 8'h64, 8'h00, 8'h01, 8'h03, 8'h00};
        exp_t = '{8'h01, 8'h00, 8'h11, 8'h00, 8'h00, 8'h02, 8'h06, 8'h00, 8'h00, 8'h01, 8'h64, 8'h00,
                  8'h01, 8'h03, 8'h07, 8'h00, 8'h20, 8'h00, 8'h64, 8'h00, 8'h01, 8'h03, 8'h00};
        exp_b[8] = 8'(DENS_B / 4 - 1);
        repeat (3) @(posedge ref_clk);
        check(32'({dq_b, dq_t}), 32'h0);
        check(32'({oe_b_n, oe_t_n}), 32'h3);
        #DLY;
        rst_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #DLY;
        check(32'({dq_b, dq_t}), 32'h0);
        check(32'({oe_b_n, oe_t_n}), 32'h3);
        $display("test reset done");
        host.fetch_base();
        check(32'(host.base), 32'h39);
        rd(8'h16, 8'h00, 8'h00);
        rd(8'h52, 8'h02, 8'h02);
        rd(8'h55, 8'h11, 8'h11);
        rd(8'h53, 8'h01, 8'(DENS_T / 4 - 1));
        rd(8'h77, 8'h00, 8'h00);
        rd(8'ha0, 8'h00, 8'h00);
        $display("test single reads done");
        for (int i = 0; i < 23; i++)
        begin
            host.point_rel(8'(8'h28 + i));
            repeat (3) @(posedge ref_clk);
            #DLY;
            got_b[i] = dq_b[7:0];
            got_t[i] = dq_t[7:0];
            check(32'(dq_b), {24'h0, exp_b[i]});
            check(32'(dq_t), {24'h0, exp_t[i]});
        end
        host.release_pins();
        $display("test streamed scan done");
        check(32'({got_b[9], got_b[8]}), 32'(DENS_B / 4 - 1));
        check(32'({got_t[1], got_t[0]}), 32'h1);
        check(32'({got_b[10][7:4], got_b[10][3:0]}), 32'h11);
        check(geo_bits(got_b[14], got_b[15], got_b[16], got_b[17]), 32'd4194304);
        check(32'({got_b[17], got_b[16]}) * 32'd256, 32'h10000);
        check(geo_bits(got_t[6], got_t[7], got_t[8], got_t[9]) + geo_bits(got_t[14], got_t[15], got_t[16],
              got_t[17]), 32'd4194304);
        check(32'({got_b[19], got_b[18]}) * 32'd1000, 32'd100000);
        check(32'({got_t[11], got_t[10]}) * 32'd1000, 32'd100000);
        check(32'({got_t[12][4], got_t[12][3:0]}), 32'h01);
        check(32'({got_t[13][7:3], got_t[13][2], got_t[13][1:0]}), 32'h03);
        $display("test field decode done");
        @(posedge ref_clk);
        #DLY;
        rst_n = 1'b0;
        #DLY;
        check(32'({dq_b, dq_t}), 32'h0);
        check(32'({oe_b_n, oe_t_n}), 32'h3);
        @(posedge ref_clk);
        #DLY;
        rst_n = 1'b1;
        rd(8'h6e, 8'h01, 8'h03);
        $display("test second reset done");
        summarize();
    end
endmodule
